// ==== hdl/nisc_controller.sv ====
// module: nested interrupt sequencer with stack pointer and context save/restore
// How it works
// [R1] 16-bit pointer to next free byte, resets 01FF
// [R2] decrement after push, increment before pop
// [R3] 256-byte stack, upper byte forced
// [R4] reset or reset-stack sets low byte ones
// [R5] pointer wraps silently both directions
// [R6] low pointer byte readable and writable
// [R7] program counter low byte pushed first
// [R8] call uses two bytes, interrupt five
// [R9] four software nesting levels
// [R10] sixteen fixed vectors FFE0 to FFFF
// [R11] reset, trap unmaskable; top level maskable
// [R12] mask level at condition code bits 5,3
// [R13] finish current instruction before entry
// [R14] save pc, index, accumulator, condition code
// [R15] entry loads priority bits from vector setting
// [R16] pc loaded from vector, then fetch
// [R17] return restores all, priority bits too
// [R18] level encoding 10,01,00,11 low to high
// [R19] service only above level; hardware order ties
// [R20] pointer five lower inside, restored after return
`timescale 1ns/10ps
module nisc_controller #(
   parameter int NVEC = nisc_pkg::NUM_VECTORS
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic [NVEC-1:0] irqReq,
   input wire logic trapReq,
   input wire logic instrDone,
   input wire logic resetStackInstruction,
   input wire logic returnFromInterrupt,
   input wire logic callPush,
   input wire logic retPop,
   input wire nisc_pkg::nisc_ctx_t cpuCtx,
   input wire logic [7:0] memRdata,
   output nisc_pkg::nisc_mem_t memReq,
   output logic [3:0] vecIndex,
   output logic [15:0] vecAddr,
   output logic fetchVector,
   output logic busy,
   output nisc_pkg::nisc_ctx_t restCtx,
   output logic restValid,
   output logic [15:0] stackPointerOut
);
   import nisc_pkg::*;

   logic [7:0] spLow_r;
   logic [7:0] cc_r;
   logic [1:0] swPrio_r [NVEC];
   nisc_state_t state_r;
   logic [2:0] byteCnt_r;
   logic [3:0] win_r;
   logic [1:0] winPrio_r;
   logic trapPend_r;
   logic [NVEC-1:0] pend_r;
   nisc_ctx_t saved_r;
   logic [7:0] rdata_r;

   // level rank: 0 lowest .. 3 highest
   function automatic logic [1:0] rankOf(input logic [1:0] bits);
      case (bits)
         LVL0_BITS: rankOf = 2'h0;
         LVL1_BITS: rankOf = 2'h1;
         LVL2_BITS: rankOf = 2'h2;
         default: rankOf = 2'h3;
      endcase // R18
   endfunction : rankOf

   logic [1:0] curBits;
   assign curBits = {cc_r[PRIO_HI_POS], cc_r[PRIO_LO_POS]}; // R12

   // vector 0 is the highest hardware priority (top level); trap wins over all
   logic found;
   logic [3:0] best;
   logic [1:0] bestRank;
   always_comb begin
      found = 1'b0;
      best = 4'h0;
      bestRank = 2'h0;
      for (int i = NVEC - 1; i >= 0; i--) begin
         if (pend_r[i] && rankOf(swPrio_r[i]) > rankOf(curBits)
             && (!found || rankOf(swPrio_r[i]) >= bestRank)) begin // R19 R9
            found = 1'b1;
            best = 4'(i);
            bestRank = rankOf(swPrio_r[i]);
         end
      end
   end

   // top-level vector 0 may be masked too; trap ignores the level
   logic takeTrap;
   logic takeIrq;
   assign takeTrap = trapPend_r && instrDone; // R11 R13
   assign takeIrq = found && instrDone && !trapPend_r; // R13

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pend_r <= '0;
         trapPend_r <= 1'b0;
      end else begin
         pend_r <= irqReq;
         if (trapReq) begin
            trapPend_r <= 1'b1;
         end else if (state_r == NISC_IDLE && takeTrap) begin
            trapPend_r <= 1'b0;
         end
      end
   end

   // software priority settings, one two-bit field per vector
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < NVEC; i++) begin
            swPrio_r[i] <= LVL3_BITS;
         end
      end else if (regWr && regAddr >= ADDR_PRIO_BASE
                   && regAddr < ADDR_PRIO_BASE + 4'(PRIO_REGS)) begin
         for (int j = 0; j < 4; j++) begin
            if ((int'(regAddr - ADDR_PRIO_BASE) * 4 + j) < NVEC) begin
               swPrio_r[int'(regAddr - ADDR_PRIO_BASE) * 4 + j] <= regWdata[2*j +: 2];
            end
         end
      end
   end

   // sequencer
   logic [15:0] spFull;
   assign spFull = {SP_HIGH_FIXED, spLow_r}; // R1 R3

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r <= NISC_IDLE;
         byteCnt_r <= 3'h0;
         win_r <= 4'h0;
         winPrio_r <= LVL3_BITS;
         saved_r <= '0;
      end else begin
         case (state_r)
            NISC_IDLE: begin
               byteCnt_r <= 3'h0;
               if (takeTrap || takeIrq) begin
                  state_r <= NISC_SAVE;
                  // the level bits live here, so the saved cc is our own register
                  saved_r <= {cpuCtx.pc, cpuCtx.x, cpuCtx.a, cc_r}; // R14
                  win_r <= takeTrap ? 4'(NVEC - 1) : best;
                  winPrio_r <= takeTrap ? LVL3_BITS : swPrio_r[best]; // R15
               end else if (returnFromInterrupt) begin
                  state_r <= NISC_REST;
               end
            end
            NISC_SAVE: begin
               byteCnt_r <= byteCnt_r + 3'h1;
               if (byteCnt_r == 3'(CTX_BYTES - 1)) begin // R8
                  state_r <= NISC_VECT;
               end
            end
            NISC_VECT: begin
               state_r <= NISC_RUN;
            end
            NISC_RUN: begin
               state_r <= NISC_IDLE;
            end
            NISC_REST: begin
               byteCnt_r <= byteCnt_r + 3'h1;
               case (byteCnt_r)
                  3'h1: saved_r.cc <= memRdata;
                  3'h2: saved_r.a <= memRdata;
                  3'h3: saved_r.x <= memRdata;
                  3'h4: saved_r.pc[15:8] <= memRdata;
                  3'h5: saved_r.pc[7:0] <= memRdata;
                  default: ;
               endcase // R17
               if (byteCnt_r == 3'(CTX_BYTES)) begin
                  state_r <= NISC_IDLE;
               end
            end
            default: state_r <= NISC_IDLE;
         endcase
      end
   end

   // push order: pcl, pch, x, a, cc; pop reads them in reverse
   logic [7:0] pushByte;
   always_comb begin
      case (byteCnt_r)
         3'h0: pushByte = saved_r.pc[7:0]; // R7
         3'h1: pushByte = saved_r.pc[15:8];
         3'h2: pushByte = saved_r.x;
         3'h3: pushByte = saved_r.a;
         default: pushByte = saved_r.cc;
      endcase
   end

   logic popStep;
   assign popStep = state_r == NISC_REST && byteCnt_r < 3'(CTX_BYTES);

   // stack pointer low byte; 8-bit arithmetic wraps on its own
   always_ff @(posedge clk_sys) begin
      if (srst || resetStackInstruction) begin
         spLow_r <= SP_LOW_TOP; // R4
      end else if (state_r == NISC_SAVE) begin
         spLow_r <= spLow_r - 8'h01; // R2 R5 R20
      end else if (popStep) begin
         spLow_r <= spLow_r + 8'h01; // R2 R5 R20
      end else if (state_r == NISC_IDLE && callPush) begin
         spLow_r <= spLow_r - 8'(CALL_BYTES); // R8
      end else if (state_r == NISC_IDLE && retPop) begin
         spLow_r <= spLow_r + 8'(CALL_BYTES);
      end else if (regWr && regAddr == ADDR_SP_LOW) begin
         spLow_r <= regWdata; // R6
      end
   end

   // condition code
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cc_r <= CC_RESET;
      end else if (state_r == NISC_VECT) begin
         cc_r[PRIO_HI_POS] <= winPrio_r[1]; // R15
         cc_r[PRIO_LO_POS] <= winPrio_r[0];
      end else if (state_r == NISC_REST && byteCnt_r == 3'(CTX_BYTES)) begin
         cc_r <= saved_r.cc; // R17
      end else if (regWr && regAddr == ADDR_CC) begin
         cc_r <= regWdata;
      end
   end

   // outputs
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         memReq <= '0;
         vecIndex <= 4'h0;
         vecAddr <= 16'h0000;
         fetchVector <= 1'b0;
         busy <= 1'b0;
         restCtx <= '0;
         restValid <= 1'b0;
         stackPointerOut <= SP_RESET;
      end else begin
         memReq.we <= state_r == NISC_SAVE;
         memReq.addr <= (state_r == NISC_REST) ? {SP_HIGH_FIXED, spLow_r + 8'h01} : spFull;
         memReq.data <= pushByte;
         fetchVector <= state_r == NISC_VECT; // R16
         if (state_r == NISC_VECT) begin
            vecIndex <= win_r;
            vecAddr <= VECTOR_BASE + 16'({win_r, 1'b0}); // R10
         end
         busy <= state_r != NISC_IDLE;
         restValid <= state_r == NISC_REST && byteCnt_r == 3'(CTX_BYTES);
         if (state_r == NISC_REST && byteCnt_r == 3'(CTX_BYTES)) begin
            // the low program counter byte arrives in this same cycle
            restCtx <= {saved_r.pc[15:8], memRdata, saved_r.x, saved_r.a, saved_r.cc}; // R17
         end
         stackPointerOut <= spFull;
      end
   end

   // register read, data one cycle later
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata_r <= 8'h00;
      end else if (regRd) begin
         if (regAddr == ADDR_SP_LOW) begin
            rdata_r <= spLow_r;
         end else if (regAddr == ADDR_SP_HIGH) begin
            rdata_r <= SP_HIGH_FIXED;
         end else if (regAddr == ADDR_CC) begin
            rdata_r <= cc_r;
         end else if (regAddr == ADDR_STATUS) begin
            rdata_r <= {4'h0, busy, state_r};
         end else if (regAddr >= ADDR_PRIO_BASE && regAddr < ADDR_PRIO_BASE + 4'(PRIO_REGS)) begin
            for (int j = 0; j < 4; j++) begin
               rdata_r[2*j +: 2] <= swPrio_r[(int'(regAddr - ADDR_PRIO_BASE) * 4 + j) % NVEC];
            end
         end else begin
            rdata_r <= 8'h00;
         end
      end
   end
   assign regRdata = rdata_r;

   // checks on the stack pointer
   a_sp_reset: assert property (@(posedge clk_sys) $fell(srst) |-> stackPointerOut == SP_RESET) // R1
      else $error("stack pointer not at reset value");

   a_sp_upper: assert property (@(posedge clk_sys) disable iff (srst)
      stackPointerOut[15:8] == SP_HIGH_FIXED) // R3
      else $error("stack upper byte not fixed");

   a_sp_rsp: assert property (@(posedge clk_sys) disable iff (srst)
      resetStackInstruction |=> spLow_r == SP_LOW_TOP) // R4
      else $error("reset stack did not restore top");

   a_sp_wrap_dn: assert property (@(posedge clk_sys) disable iff (srst || resetStackInstruction)
      state_r == NISC_SAVE && spLow_r == 8'h00 |=> spLow_r == 8'hFF) // R5
      else $error("pointer did not wrap downward");

   a_sp_wrap_up: assert property (@(posedge clk_sys) disable iff (srst || resetStackInstruction)
      popStep && spLow_r == 8'hFF |=> spLow_r == 8'h00) // R5
      else $error("pointer did not wrap upward");

   a_sp_write: assert property (@(posedge clk_sys) disable iff (srst || resetStackInstruction)
      regWr && regAddr == ADDR_SP_LOW && state_r == NISC_IDLE && !callPush && !retPop
      |=> spLow_r == $past(regWdata)) // R6
      else $error("pointer low byte not written");

   a_call_push: assert property (@(posedge clk_sys) disable iff (srst || resetStackInstruction)
      state_r == NISC_IDLE && callPush |=> spLow_r == $past(spLow_r) - 8'h02) // R8
      else $error("call did not take two bytes");

   // checks on the entry and return sequences
   sequence s_entry;
      state_r == NISC_IDLE && (takeTrap || takeIrq);
   endsequence

   sequence s_save_run;
      state_r == NISC_SAVE [*5];
   endsequence

   sequence s_return;
      state_r == NISC_IDLE && returnFromInterrupt && !takeTrap && !takeIrq
      && !callPush && !retPop;
   endsequence

   a_entry_depth: assert property (@(posedge clk_sys) disable iff (srst || resetStackInstruction)
      s_entry ##1 1'b1 |-> ##5 spLow_r == $past(spLow_r, 5) - 8'h05) // R20
      else $error("entry did not consume five bytes");

   a_entry_len: assert property (@(posedge clk_sys) disable iff (srst)
      s_entry |=> s_save_run ##1 state_r == NISC_VECT) // R8
      else $error("entry save run has wrong length");

   a_entry_first: assert property (@(posedge clk_sys) disable iff (srst)
      s_entry |=> ##1 memReq.we && memReq.data == $past(cpuCtx.pc[7:0], 2)) // R7
      else $error("first byte pushed is not pc low");

   a_idle_quiet: assert property (@(posedge clk_sys) disable iff (srst)
      state_r == NISC_IDLE |=> !memReq.we) // R2
      else $error("stack written while idle");

   a_trap_unmask: assert property (@(posedge clk_sys) disable iff (srst)
      state_r == NISC_IDLE && takeTrap |=> state_r == NISC_SAVE && win_r == 4'(NVEC - 1)) // R11
      else $error("trap not taken");

   a_vector_addr: assert property (@(posedge clk_sys) disable iff (srst)
      fetchVector |-> vecAddr == VECTOR_BASE + 16'({vecIndex, 1'b0})) // R10
      else $error("vector address out of table");

   a_fetch_after: assert property (@(posedge clk_sys) disable iff (srst)
      state_r == NISC_VECT |=> fetchVector) // R16
      else $error("vector fetch missing");

   a_prio_load: assert property (@(posedge clk_sys) disable iff (srst)
      state_r == NISC_VECT |=> {cc_r[PRIO_HI_POS], cc_r[PRIO_LO_POS]} == $past(winPrio_r)) // R15
      else $error("priority bits not loaded");

   a_mask_level: assert property (@(posedge clk_sys) disable iff (srst)
      takeIrq |-> rankOf(swPrio_r[best]) > rankOf(curBits)) // R19
      else $error("request taken at or below current level");

   a_wait_instr: assert property (@(posedge clk_sys) disable iff (srst)
      state_r == NISC_IDLE && !instrDone |=> state_r != NISC_SAVE) // R13
      else $error("entry before instruction finished");

   a_rest_level: assert property (@(posedge clk_sys) disable iff (srst)
      state_r == NISC_REST && byteCnt_r == 3'(CTX_BYTES) |=> cc_r == $past(saved_r.cc)) // R17
      else $error("level bits not restored");

   a_ret_depth: assert property (@(posedge clk_sys) disable iff (srst || resetStackInstruction)
      s_return ##1 1'b1 |-> ##5 spLow_r == $past(spLow_r, 5) + 8'h05) // R20
      else $error("return did not release five bytes");
endmodule : nisc_controller

// ==== hdl/nisc_pkg.sv ====
// package: constants and carrier types of the nested interrupt and stack control
package nisc_pkg;
   localparam logic [15:0] SP_RESET = 16'h01FF;
   localparam logic [7:0] SP_HIGH_FIXED = 8'h01;
   localparam logic [7:0] SP_LOW_TOP = 8'hFF;
   localparam logic [15:0] VECTOR_BASE = 16'hFFE0;
   localparam int NUM_VECTORS = 16;
   localparam int CTX_BYTES = 5;
   localparam int CALL_BYTES = 2;
   localparam int PRIO_HI_POS = 5;
   localparam int PRIO_LO_POS = 3;
   localparam logic [1:0] LVL0_BITS = 2'h2;
   localparam logic [1:0] LVL1_BITS = 2'h1;
   localparam logic [1:0] LVL2_BITS = 2'h0;
   localparam logic [1:0] LVL3_BITS = 2'h3;
   localparam logic [3:0] ADDR_SP_LOW = 4'h0;
   localparam logic [3:0] ADDR_SP_HIGH = 4'h1;
   localparam logic [3:0] ADDR_CC = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_PRIO_BASE = 4'h4;
   localparam logic [7:0] CC_RESET = 8'h28;
   localparam int PRIO_REGS = 4;

   typedef enum logic [2:0] {
      NISC_IDLE = 3'h0,
      NISC_SAVE = 3'h1,
      NISC_VECT = 3'h3,
      NISC_RUN = 3'h2,
      NISC_REST = 3'h6
   } nisc_state_t;

   typedef struct packed {
      logic [15:0] pc;
      logic [7:0] x;
      logic [7:0] a;
      logic [7:0] cc;
   } nisc_ctx_t;

   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [7:0] data;
   } nisc_mem_t;
endpackage : nisc_pkg

// ==== testbench/nisc_periph_model.sv ====
// peripheral request lines and stack memory around the controller
`timescale 1ns/10ps
module nisc_periph_model (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [15:0] raise,
   input wire logic [15:0] drop,
   output logic [15:0] irqReq,
   input wire nisc_pkg::nisc_mem_t memReq,
   output logic [7:0] memRdata
);
   import nisc_pkg::*;
   logic [7:0] stackMem [256];
   // requests are levels held until the bench drops them
   always_ff @(posedge clk_sys) begin
      if (srst) irqReq <= 16'h0000;
      else irqReq <= (irqReq | raise) & ~drop;
   end
   always_ff @(posedge clk_sys) begin
      if (memReq.we) stackMem[memReq.addr[7:0]] <= memReq.data;
   end
   // read data follow the registered address within the same cycle
   assign memRdata = stackMem[memReq.addr[7:0]];
endmodule : nisc_periph_model

// ==== testbench/nisc_controller_tb_top.sv ====
// self-checking bench for the nested interrupt and stack controller
`timescale 1ns/10ps
module nisc_controller_tb_top;
   import nisc_pkg::*;
   logic clk_sys, srst, regWr, regRd, trapReq, instrDone, rsi, rfi, callPush, retPop;
   logic fetchVector, busy, restValid;
   logic [3:0] regAddr, vecIndex;
   logic [7:0] regWdata, regRdata, memRdata, rd, v;
   logic [15:0] irqReq, raise, drop, vecAddr, sp;
   nisc_ctx_t cpuCtx, restCtx;
   nisc_ctx_t ctxQ[$];
   logic [15:0] spQ[$];
   nisc_mem_t memReq;
   int failures, checksDone, i;
   logic [31:0] seed;
   nisc_controller nisc_controller_inst (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqReq(irqReq),
      .trapReq(trapReq), .instrDone(instrDone), .resetStackInstruction(rsi),
      .returnFromInterrupt(rfi), .callPush(callPush), .retPop(retPop), .cpuCtx(cpuCtx),
      .memRdata(memRdata), .memReq(memReq), .vecIndex(vecIndex), .vecAddr(vecAddr),
      .fetchVector(fetchVector), .busy(busy), .restCtx(restCtx), .restValid(restValid),
      .stackPointerOut(sp));
   nisc_periph_model nisc_periph_model_inst (.clk_sys(clk_sys), .srst(srst), .raise(raise),
      .drop(drop), .irqReq(irqReq), .memReq(memReq), .memRdata(memRdata));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [15:0] expSp(input logic [7:0] low, input logic [7:0] delta);
      return {SP_HIGH_FIXED, 8'(low + delta)};
   endfunction : expSp
   task automatic end_of_test();
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checksDone++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : wr
   task automatic rdr(input logic [3:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 rd = regRdata;
   endtask : rdr
   // one-cycle strobe: 0 stack reset, 1 call push, 2 return pop, 3 interrupt return
   task automatic pulse(input int k);
      @(posedge clk_sys);
      {rfi, retPop, callPush, rsi} <= 4'(1 << k);
      @(posedge clk_sys);
      {rfi, retPop, callPush, rsi} <= 4'h0;
   endtask : pulse
   task automatic waitSig(input int bound, input bit rest, output bit got);
      got = 1'b0;
      repeat (bound) begin
         @(posedge clk_sys);
         #1;
         if ((rest ? restValid : fetchVector) === 1'b1) begin
            got = 1'b1;
            break;
         end
      end
   endtask : waitSig
   task automatic waitIdle();
      for (i = 0; i < 20 && busy !== 1'b0; i++) begin
         @(posedge clk_sys);
         #1;
      end
      if (busy !== 1'b0) begin
         failures++;
         end_of_test();
      end
   endtask : waitIdle
   task automatic entry(input logic [15:0] r, input bit t, input int idx, input logic [1:0] lv);
      bit got;
      @(posedge clk_sys);
      spQ.push_back(sp);
      ctxQ.push_back(cpuCtx);
      raise <= r;
      trapReq <= t;
      @(posedge clk_sys);
      raise <= 16'h0000;
      trapReq <= 1'b0;
      if (instrDone !== 1'b1) begin
         waitSig(8, 1'b0, got);
         chk(16'(got), 16'h0000, "entry before instruction end");
         instrDone <= 1'b1;
      end
      waitSig(40, 1'b0, got);
      chk(16'(got), 16'h0001, "vector fetch");
      if (!got) end_of_test();
      chk(16'(vecIndex), 16'(idx), "serviced vector");
      chk(vecAddr, VECTOR_BASE + 16'(2 * idx), "vector address");
      chk(sp, spQ[$] - 16'(CTX_BYTES), "sp after entry");
      chk(16'(nisc_periph_model_inst.stackMem[spQ[$][7:0]]), 16'(ctxQ[$].pc[7:0]), "pcl");
      rdr(ADDR_CC);
      chk(16'({rd[PRIO_HI_POS], rd[PRIO_LO_POS]}), 16'(lv), "level on entry");
   endtask : entry
   task automatic doReturn(input logic [1:0] lv);
      bit got;
      waitIdle();
      pulse(3);
      waitSig(40, 1'b1, got);
      chk(16'(got), 16'h0001, "return done");
      if (!got) end_of_test();
      chk({restCtx.pc}, ctxQ[$].pc, "restored pc");
      chk({restCtx.x, restCtx.a}, {ctxQ[$].x, ctxQ[$].a}, "restored x a");
      waitIdle();
      chk(sp, spQ[$], "sp after return");
      rdr(ADDR_CC);
      chk(16'({rd[PRIO_HI_POS], rd[PRIO_LO_POS]}), 16'(lv), "level after return");
      void'(ctxQ.pop_back());
      void'(spQ.pop_back());
   endtask : doReturn
   initial begin
      {regWr, regRd, trapReq, instrDone, rsi, rfi, callPush, retPop} = 8'h00;
      {regAddr, regWdata, raise, drop, cpuCtx} = '0;
      {failures, checksDone} = 0;
      seed = 32'h33;
      srst = 1'b1;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      #1 chk(sp, SP_RESET, "sp reset");
      rdr(ADDR_SP_HIGH);
      chk(16'(rd), 16'(SP_HIGH_FIXED), "sp high");
      rdr(ADDR_CC);
      chk(16'(rd), 16'(CC_RESET), "cc reset level 3");
      rdr(4'hC);
      chk(16'(rd), 16'h0000, "unmapped read");
      for (int n = 0; n < 10; n++) begin
         v = (n < 2) ? 8'(n) : 8'(xs());
         wr(ADDR_SP_LOW, v);
         rdr(ADDR_SP_LOW);
         chk(16'(rd), 16'(v), "sp low readback");
         pulse(1);
         @(posedge clk_sys);
         #1 chk(sp, expSp(v, 8'hFE), "call push wraps");
         pulse(2);
         @(posedge clk_sys);
         #1 chk(sp, expSp(v, 8'h00), "call pop");
      end
      pulse(0);
      @(posedge clk_sys);
      #1 chk(sp, SP_RESET, "stack reset");
      wr(ADDR_CC, 8'h20);
      wr(ADDR_PRIO_BASE + 4'h1, 8'hD7);
      wr(ADDR_PRIO_BASE + 4'h2, 8'hF3);
      cpuCtx <= 40'({xs(), xs()});
      entry(16'h0060, 1'b0, 5, LVL1_BITS);
      drop <= 16'h0020;
      waitSig(8, 1'b0, v[0]);
      chk(16'(v[0]), 16'h0000, "equal level not nested");
      cpuCtx <= 40'({xs(), xs()});
      entry(16'h0200, 1'b0, 9, LVL2_BITS);
      drop <= 16'h0240;
      doReturn(LVL1_BITS);
      doReturn(LVL0_BITS);
      wr(ADDR_CC, CC_RESET);
      cpuCtx <= 40'({xs(), xs()});
      entry(16'h0000, 1'b1, NUM_VECTORS - 1, LVL3_BITS);
      doReturn(LVL3_BITS);
      end_of_test();
   end
endmodule : nisc_controller_tb_top
